/* File: ocd_map.svh */
// Address map, field positions, reset values for the configuration decoder.
// Assumes a 12-bit APB byte address with one 32-bit word per register.
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH

`define OCD_ADDR_W 12
`define OCD_ADDR_CFG_A 12'h000
`define OCD_ADDR_CFG_B 12'h004
`define OCD_ADDR_STATUS 12'h008

// Operation configuration word A fields.
`define OCD_A_PFET_LSB 0
`define OCD_A_SERIAL 2
`define OCD_A_TEMP_LSB 3
`define OCD_A_SLEEP 5
`define OCD_A_ZERO_MASK 16'h00C0
`define OCD_A_CELLS_LSB 8
`define OCD_A_LEDS_LSB 10
`define OCD_A_ABS 12
`define OCD_A_CHG_DISPLAY 13
`define OCD_A_RCALED 14
`define OCD_A_RSTLED 15

// Operation configuration word B fields.
`define OCD_B_BROADCAST 0
`define OCD_B_HOST_PEC 1
`define OCD_B_CHG_PEC 2

// Reset values: thermistor one as source, parallel display mode.
`define OCD_CFG_A_RST 16'h0008
`define OCD_CFG_B_RST 16'h0000

// Status word bits.
`define OCD_ST_ZERO_ERR 0
`define OCD_ST_CELL_BAD 1
`define OCD_ST_ACT_SEEN 2

`endif

/* File: ocd_pkg.sv */
// Types shared by the configuration decoder modules.
// Assumes ocd_map.svh supplies the numeric layout.
package ocd_pkg;

	// One-hot temperature source selection.
	typedef enum logic [3:0] {
		OCD_TEMP_INTERNAL = 4'h1,
		OCD_TEMP_THERM_ONE = 4'h2,
		OCD_TEMP_MAX = 4'h4,
		OCD_TEMP_AVG = 4'h8
	} ocd_temp_src_e;

	// One-hot precharge FET selection; all zero means no action.
	typedef enum logic [2:0] {
		OCD_PFET_NONE = 3'h0,
		OCD_PFET_ZERO_VOLT = 3'h1,
		OCD_PFET_CHARGE = 3'h2,
		OCD_PFET_OD = 3'h4
	} ocd_pfet_e;

	typedef logic [15:0] ocd_word_t;

endpackage

/* File: ocd_select_decode.sv */
// Registered decode of the two stored configuration words into selects.
// Assumes the words come from flip-flops in the same clock domain.
`timescale 1ns/1ps
`include "ocd_map.svh"

module ocd_select_decode import ocd_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire ocd_word_t cfg_a,
	input wire ocd_word_t cfg_b,
	output ocd_pfet_e pfet_sel_r,
	output ocd_temp_src_e temp_src_r,
	output logic serial_mode_r,
	output logic sleep_permit_r,
	output logic [2:0] cells_r,
	output logic [2:0] leds_r,
	output logic abs_mode_r,
	output logic broadcast_r,
	output logic host_pec_r,
	output logic chg_pec_r
);

	// Maps a two-bit code to base+code; code zero maps to zero.
	function automatic logic [2:0] count_of(input logic [1:0] code,
		input logic [2:0] base);
		count_of = (code == 2'h0) ? 3'h0 : 3'(base + {1'b0, code});
	endfunction

	function automatic ocd_pfet_e pfet_of(input logic [1:0] code);
		unique case (code)
			2'h0: pfet_of = OCD_PFET_ZERO_VOLT;
			2'h1: pfet_of = OCD_PFET_CHARGE;
			2'h2: pfet_of = OCD_PFET_OD;
			2'h3: pfet_of = OCD_PFET_NONE;
		endcase
	endfunction

	function automatic ocd_temp_src_e temp_of(input logic [1:0] code);
		unique case (code)
			2'h0: temp_of = OCD_TEMP_INTERNAL;
			2'h1: temp_of = OCD_TEMP_THERM_ONE;
			2'h2: temp_of = OCD_TEMP_MAX;
			2'h3: temp_of = OCD_TEMP_AVG;
		endcase
	endfunction

	ocd_pfet_e pfet_nxt;
	ocd_temp_src_e temp_nxt;
	logic [2:0] cells_nxt, leds_nxt;

	// Next select values follow the stored words in the same cycle.
	always_comb begin
		pfet_nxt = pfet_of(cfg_a[`OCD_A_PFET_LSB +: 2]);
		temp_nxt = temp_of(cfg_a[`OCD_A_TEMP_LSB +: 2]);
		cells_nxt = count_of(cfg_a[`OCD_A_CELLS_LSB +: 2], 3'h1);
		leds_nxt = count_of(cfg_a[`OCD_A_LEDS_LSB +: 2], 3'h2);
	end

	// Selects hold steady between writes; reset gives the defaults.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pfet_sel_r <= OCD_PFET_ZERO_VOLT;
			temp_src_r <= OCD_TEMP_THERM_ONE;
			serial_mode_r <= 1'b0;
			sleep_permit_r <= 1'b0;
			cells_r <= 3'h0;
			leds_r <= 3'h0;
			abs_mode_r <= 1'b0;
			broadcast_r <= 1'b0;
			host_pec_r <= 1'b0;
			chg_pec_r <= 1'b0;
		end else begin
			pfet_sel_r <= pfet_nxt;
			temp_src_r <= temp_nxt;
			serial_mode_r <= cfg_a[`OCD_A_SERIAL];
			sleep_permit_r <= cfg_a[`OCD_A_SLEEP];
			cells_r <= cells_nxt;
			leds_r <= leds_nxt;
			abs_mode_r <= cfg_a[`OCD_A_ABS];
			broadcast_r <= cfg_b[`OCD_B_BROADCAST];
			host_pec_r <= cfg_b[`OCD_B_HOST_PEC];
			chg_pec_r <= cfg_b[`OCD_B_CHG_PEC];
		end
	end

endmodule

/* File: ocd_display_trigger.sv */
// Indicator activation: button, bus command, alarm edge, reset exit.
// Assumes all event inputs are synchronous to clock.
`timescale 1ns/1ps

module ocd_display_trigger (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic on_charge_en,
	input wire logic on_alarm_en,
	input wire logic on_reset_en,
	input wire logic charging,
	input wire logic remaining_capacity_alarm,
	input wire logic display_button,
	input wire logic bus_display_cmd,
	input wire logic device_in_reset,
	output logic activate_r,
	output logic charge_display_r
);

	logic alarm_prev_r, alarm_prev_nxt;
	logic rst_prev_r, rst_prev_nxt;
	logic activate_nxt, charge_display_nxt;

	// Only the rising alarm edge counts, so a standing alarm fires once.
	always_comb begin
		alarm_prev_nxt = remaining_capacity_alarm;
		rst_prev_nxt = device_in_reset;
		activate_nxt = display_button | bus_display_cmd;
		if (on_alarm_en && remaining_capacity_alarm && !alarm_prev_r) begin
			activate_nxt = 1'b1;
		end
		if (on_reset_en && rst_prev_r && !device_in_reset) begin
			activate_nxt = 1'b1;
		end
		charge_display_nxt = on_charge_en & charging;
	end

	// The reset history starts high so a first release still counts.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alarm_prev_r <= 1'b0;
			rst_prev_r <= 1'b1;
			activate_r <= 1'b0;
			charge_display_r <= 1'b0;
		end else begin
			alarm_prev_r <= alarm_prev_nxt;
			rst_prev_r <= rst_prev_nxt;
			activate_r <= activate_nxt;
			charge_display_r <= charge_display_nxt;
		end
	end

endmodule

/* File: ocd_config_decoder.sv */
// Top of the operation configuration decoder with its APB register slave.
// Assumes an APB master on clock; all side inputs are synchronous.
`timescale 1ns/1ps
`include "ocd_map.svh"

module ocd_config_decoder import ocd_pkg::*; (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`OCD_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic charging,
	input wire logic remaining_capacity_alarm,
	input wire logic display_button,
	input wire logic bus_display_cmd,
	input wire logic device_in_reset,
	input wire logic sleep_conditions_met,
	input wire logic broadcast_request,
	output logic [2:0] precharge_fet_sel,
	output logic serial_indicator_mode,
	output logic [3:0] thermal_source_sel,
	output logic sleep_enter,
	output logic [2:0] series_cells,
	output logic cell_count_invalid,
	output logic [2:0] indicator_count,
	output logic indicator_user_ctrl,
	output logic absolute_charge_display,
	output logic display_activate,
	output logic display_while_charging,
	output logic broadcast_send,
	output logic host_alarm_checksum,
	output logic charger_alarm_checksum
);

	ocd_word_t cfg_a_r, cfg_a_nxt;
	ocd_word_t cfg_b_r, cfg_b_nxt;
	logic zero_err_r, zero_err_nxt;
	logic act_seen_r, act_seen_nxt;
	logic access, wr_en, hit_a, hit_b, hit_st;
	ocd_pfet_e pfet_sel;
	ocd_temp_src_e temp_src;
	logic sleep_permit;
	logic bc_permit;

	// Address decode; the slave never inserts wait states.
	always_comb begin
		access = psel & penable;
		hit_a = (paddr == `OCD_ADDR_CFG_A);
		hit_b = (paddr == `OCD_ADDR_CFG_B);
		hit_st = (paddr == `OCD_ADDR_STATUS);
		wr_en = access & pwrite;
		pready = 1'b1;
		pslverr = access & ~(hit_a | hit_b | hit_st);
	end

	// Read data is a mux of flip-flops; unmapped reads return zero.
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_a) begin
			prdata = {16'h0000, cfg_a_r};
		end else if (hit_b) begin
			prdata = {16'h0000, cfg_b_r};
		end else if (hit_st) begin
			prdata[`OCD_ST_ZERO_ERR] = zero_err_r;
			prdata[`OCD_ST_CELL_BAD] = cell_count_invalid;
			prdata[`OCD_ST_ACT_SEEN] = act_seen_r;
		end
	end

	// Register writes. Reserved bits of word A are forced to zero so a
	// careless write cannot leave them set, and the attempt is flagged.
	always_comb begin
		cfg_a_nxt = cfg_a_r;
		cfg_b_nxt = cfg_b_r;
		zero_err_nxt = zero_err_r;
		act_seen_nxt = act_seen_r;
		if (wr_en && hit_a) begin
			cfg_a_nxt = pwdata[15:0] & ~`OCD_A_ZERO_MASK;
		end
		if (wr_en && hit_b) begin
			cfg_b_nxt = pwdata[15:0];
		end
		if (wr_en && hit_st && pwdata[`OCD_ST_ZERO_ERR]) begin
			zero_err_nxt = 1'b0;
		end
		if (wr_en && hit_st && pwdata[`OCD_ST_ACT_SEEN]) begin
			act_seen_nxt = 1'b0;
		end
		// A new event in the clearing cycle wins over the clear.
		if (wr_en && hit_a && |(pwdata[15:0] & `OCD_A_ZERO_MASK)) begin
			zero_err_nxt = 1'b1;
		end
		if (display_activate) begin
			act_seen_nxt = 1'b1;
		end
	end

	// Stored words and sticky status flags.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_a_r <= `OCD_CFG_A_RST;
			cfg_b_r <= `OCD_CFG_B_RST;
			zero_err_r <= 1'b0;
			act_seen_r <= 1'b0;
		end else begin
			cfg_a_r <= cfg_a_nxt;
			cfg_b_r <= cfg_b_nxt;
			zero_err_r <= zero_err_nxt;
			act_seen_r <= act_seen_nxt;
		end
	end

	// Field decode into held selects.
	ocd_select_decode u_decode (
		.clock(clock),
		.rst_n(rst_n),
		.cfg_a(cfg_a_r),
		.cfg_b(cfg_b_r),
		.pfet_sel_r(pfet_sel),
		.temp_src_r(temp_src),
		.serial_mode_r(serial_indicator_mode),
		.sleep_permit_r(sleep_permit),
		.cells_r(series_cells),
		.leds_r(indicator_count),
		.abs_mode_r(absolute_charge_display),
		.broadcast_r(bc_permit),
		.host_pec_r(host_alarm_checksum),
		.chg_pec_r(charger_alarm_checksum)
	);

	// Indicator activation sources.
	ocd_display_trigger u_trigger (
		.clock(clock),
		.rst_n(rst_n),
		.on_charge_en(cfg_a_r[`OCD_A_CHG_DISPLAY]),
		.on_alarm_en(cfg_a_r[`OCD_A_RCALED]),
		.on_reset_en(cfg_a_r[`OCD_A_RSTLED]),
		.charging(charging),
		.remaining_capacity_alarm(remaining_capacity_alarm),
		.display_button(display_button),
		.bus_display_cmd(bus_display_cmd),
		.device_in_reset(device_in_reset),
		.activate_r(display_activate),
		.charge_display_r(display_while_charging)
	);

	// Gating outputs are handshakes, so they follow their request at once.
	always_comb begin
		precharge_fet_sel = pfet_sel;
		thermal_source_sel = temp_src;
		sleep_enter = sleep_permit & sleep_conditions_met;
		broadcast_send = bc_permit & broadcast_request;
		cell_count_invalid = (series_cells == 3'h0);
		indicator_user_ctrl = (indicator_count == 3'h0);
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_RESERVED_ZERO: assert property (
		(cfg_a_r & `OCD_A_ZERO_MASK) == 16'h0000)
		else $error("Reserved bits of word A were stored as nonzero.");

	AST_RESERVED_FLAG: assert property (
		wr_en && hit_a && |(pwdata[15:0] & `OCD_A_ZERO_MASK) |=>
		zero_err_r)
		else $error("Reserved-bit write did not raise the error flag.");

	AST_PFET_MAP: assert property (
		##1 precharge_fet_sel == ($past(cfg_a_r[1:0]) == 2'h0 ? 3'h1 :
		$past(cfg_a_r[1:0]) == 2'h1 ? 3'h2 :
		$past(cfg_a_r[1:0]) == 2'h2 ? 3'h4 : 3'h0))
		else $error("Precharge FET select does not match its code.");

	AST_SERIAL_MODE: assert property (
		$changed(cfg_a_r[`OCD_A_SERIAL]) |=>
		serial_indicator_mode == $past(cfg_a_r[`OCD_A_SERIAL]))
		else $error("Display mode did not follow its bit.");

	AST_TEMP_MAP: assert property (
		##1 thermal_source_sel == (4'h1 << $past(cfg_a_r[4:3])))
		else $error("Temperature source select does not match its code.");

	AST_SLEEP_GATE: assert property (
		sleep_enter |-> sleep_conditions_met && $past(cfg_a_r[`OCD_A_SLEEP]))
		else $error("Sleep entered without permission or conditions.");

	AST_CELLS: assert property (
		##1 $past(cfg_a_r[9:8]) != 2'h0 |->
		series_cells == 3'($past(cfg_a_r[9:8])) + 3'h1 && !cell_count_invalid)
		else $error("Series cell count does not match its code.");

	AST_LEDS: assert property (
		##1 $past(cfg_a_r[11:10]) == 2'h3 |->
		indicator_count == 3'h5 && !indicator_user_ctrl)
		else $error("Five-indicator code not decoded.");

	AST_ABS_MODE: assert property (
		$rose(cfg_a_r[`OCD_A_ABS]) |=> absolute_charge_display [*1])
		else $error("Absolute display did not follow its bit.");

	AST_CHG_DISPLAY: assert property (
		charging && cfg_a_r[`OCD_A_CHG_DISPLAY] |=> display_while_charging)
		else $error("Indicator not active while charging.");

	AST_ALARM_ACT: assert property (
		$rose(remaining_capacity_alarm) && cfg_a_r[`OCD_A_RCALED]
		|=> display_activate)
		else $error("Capacity alarm did not activate the indicator.");

	AST_NO_SPURIOUS: assert property (
		display_activate |-> $past(display_button || bus_display_cmd) ||
		($past(remaining_capacity_alarm) &&
		!$past(remaining_capacity_alarm, 2) &&
		$past(cfg_a_r[`OCD_A_RCALED])) ||
		(!$past(device_in_reset) && $past(device_in_reset, 2) &&
		$past(cfg_a_r[`OCD_A_RSTLED])))
		else $error("Indicator activated with no cause.");

	AST_RESET_EXIT: assert property (
		$fell(device_in_reset) && cfg_a_r[`OCD_A_RSTLED] |=> display_activate)
		else $error("Reset exit did not activate the indicator.");

	AST_BROADCAST: assert property (
		broadcast_request && !cfg_b_r[`OCD_B_BROADCAST] ##1
		!cfg_b_r[`OCD_B_BROADCAST] |-> !broadcast_send)
		else $error("Broadcast sent while suppressed.");

	AST_HOST_PEC: assert property (
		##1 host_alarm_checksum == $past(cfg_b_r[`OCD_B_HOST_PEC]))
		else $error("Host checksum enable does not follow its bit.");

	AST_CHG_PEC: assert property (
		##1 charger_alarm_checksum == $past(cfg_b_r[`OCD_B_CHG_PEC]))
		else $error("Charger checksum enable does not follow its bit.");

	AST_STABLE: assert property (
		$stable(cfg_a_r) [*2] |-> $stable(thermal_source_sel) &&
		$stable(series_cells) && $stable(precharge_fet_sel))
		else $error("Selects changed with no write.");

	// Storage seen from the bus side: a word moves only on its own write.
	AST_WRITE_A: assert property (
		psel && penable && pwrite && paddr == `OCD_ADDR_CFG_A |=>
		cfg_a_r == ($past(pwdata[15:0]) & ~`OCD_A_ZERO_MASK))
		else $error("Word A write was not stored.");

	AST_WRITE_B: assert property (
		psel && penable && pwrite && paddr == `OCD_ADDR_CFG_B |=>
		cfg_b_r == $past(pwdata[15:0]))
		else $error("Word B write was not stored.");

	AST_NO_STRAY_WRITE: assert property (
		!(psel && penable && pwrite) |=>
		$stable(cfg_a_r) && $stable(cfg_b_r))
		else $error("Stored word changed without a write.");

	// The opposite codes of the decoded fields, so a stuck select shows.
	AST_CELL_RESERVED: assert property (
		##1 $past(cfg_a_r[9:8]) == 2'h0 |->
		series_cells == 3'h0 && cell_count_invalid)
		else $error("Reserved cell count code not flagged.");

	AST_LEDS_USER: assert property (
		##1 $past(cfg_a_r[11:10]) == 2'h0 |->
		indicator_count == 3'h0 && indicator_user_ctrl)
		else $error("User indicator control not decoded.");

	AST_LEDS_FEW: assert property (
		##1 $past(cfg_a_r[11:10]) == 2'h1 |->
		indicator_count == 3'h3 && !indicator_user_ctrl)
		else $error("Three-indicator code not decoded.");

	AST_SLEEP_PERMIT: assert property (
		$past(cfg_a_r[`OCD_A_SLEEP]) && sleep_conditions_met |->
		sleep_enter)
		else $error("Permitted sleep was not entered.");

	AST_BROADCAST_ON: assert property (
		$past(cfg_b_r[`OCD_B_BROADCAST]) && broadcast_request |->
		broadcast_send)
		else $error("Permitted broadcast was not sent.");

	AST_ABS_OFF: assert property (
		$fell(cfg_a_r[`OCD_A_ABS]) |=> !absolute_charge_display)
		else $error("Relative display did not follow its bit.");

	AST_CHG_OFF: assert property (
		!cfg_a_r[`OCD_A_CHG_DISPLAY] |=> !display_while_charging)
		else $error("Indicator kept on by charging while disabled.");

	AST_ACT_SEEN: assert property (
		display_activate |=> act_seen_r)
		else $error("Indicator activation was not recorded.");

	AST_ALARM_OFF: assert property (
		$rose(remaining_capacity_alarm) && !cfg_a_r[`OCD_A_RCALED] &&
		!display_button && !bus_display_cmd && !$fell(device_in_reset)
		|=> !display_activate)
		else $error("Capacity alarm activated the indicator while off.");

endmodule

/* File: ocd_far_side.sv */
// Far side model: battery events toward the decoder, display pulse count.
// Assumes the bench sets the wanted event levels just after a rising edge.
`timescale 1ns/1ps

module ocd_far_side (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [6:0] want,
	input wire logic display_activate,
	output logic charging,
	output logic remaining_capacity_alarm,
	output logic display_button,
	output logic bus_display_cmd,
	output logic device_in_reset,
	output logic sleep_conditions_met,
	output logic broadcast_request,
	output int pulses
);
	// Events leave a flop, so they change one edge after the bench asks.
	// Counting pulses lets the bench judge activations without exact timing.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{broadcast_request, sleep_conditions_met, device_in_reset,
				bus_display_cmd, display_button, remaining_capacity_alarm,
				charging} <= 7'h00;
			pulses <= 0;
		end else begin
			{broadcast_request, sleep_conditions_met, device_in_reset,
				bus_display_cmd, display_button, remaining_capacity_alarm,
				charging} <= want;
			if (display_activate) begin
				pulses <= pulses + 1;
			end
		end
	end
endmodule

/* File: tb.sv */
// Self-checking bench for the configuration decoder over APB.
// Assumes zero wait APB slave and the far side model beside it.
`timescale 1ns/1ps
`include "ocd_map.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
	$display("Error %s expected %0h seen %0h", n, e, s); end end

module tb import ocd_pkg::*; ;
	logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [`OCD_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rv;
	logic pready, pslverr, er;
	logic [6:0] want = '0;
	int fails = 0, checks = 0, p0;
	logic charging, remaining_capacity_alarm, display_button;
	logic bus_display_cmd, device_in_reset, sleep_conditions_met;
	logic broadcast_request, serial_indicator_mode, sleep_enter;
	logic cell_count_invalid, indicator_user_ctrl, absolute_charge_display;
	logic display_activate, display_while_charging, broadcast_send;
	logic host_alarm_checksum, charger_alarm_checksum;
	logic [2:0] precharge_fet_sel, series_cells, indicator_count;
	logic [3:0] thermal_source_sel;
	int pulses;

	// The clock toggles every half period of 5 ns.
	always #5 clock = ~clock;

	ocd_config_decoder uut (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.charging(charging), .remaining_capacity_alarm(remaining_capacity_alarm),
		.display_button(display_button), .bus_display_cmd(bus_display_cmd),
		.device_in_reset(device_in_reset),
		.sleep_conditions_met(sleep_conditions_met),
		.broadcast_request(broadcast_request),
		.precharge_fet_sel(precharge_fet_sel),
		.serial_indicator_mode(serial_indicator_mode),
		.thermal_source_sel(thermal_source_sel), .sleep_enter(sleep_enter),
		.series_cells(series_cells), .cell_count_invalid(cell_count_invalid),
		.indicator_count(indicator_count),
		.indicator_user_ctrl(indicator_user_ctrl),
		.absolute_charge_display(absolute_charge_display),
		.display_activate(display_activate),
		.display_while_charging(display_while_charging),
		.broadcast_send(broadcast_send),
		.host_alarm_checksum(host_alarm_checksum),
		.charger_alarm_checksum(charger_alarm_checksum));

	ocd_far_side far (.clock(clock), .rst_n(rst_n), .want(want),
		.display_activate(display_activate), .charging(charging),
		.remaining_capacity_alarm(remaining_capacity_alarm),
		.display_button(display_button), .bus_display_cmd(bus_display_cmd),
		.device_in_reset(device_in_reset),
		.sleep_conditions_met(sleep_conditions_met),
		.broadcast_request(broadcast_request), .pulses(pulses));

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// Only pready ends the access; the watchdog bounds a hang.
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Registered selects trail the stored word by one edge; settle past it.
	task automatic settle();
		repeat (3) @(posedge clock);
		#1;
	endtask

	task automatic t_reset();
		`CHK("pfet", 3'h1, precharge_fet_sel)
		`CHK("temp", 4'h2, thermal_source_sel)
		`CHK("serial", 1'b0, serial_indicator_mode)
		`CHK("invalid", 1'b1, cell_count_invalid)
		apb(1'b0, `OCD_ADDR_CFG_A, 32'h0);
		`CHK("cfg_a", 32'h00000008, rv)
		apb(1'b0, `OCD_ADDR_CFG_B, 32'h0);
		`CHK("cfg_b", 32'h00000000, rv)
	endtask

	// Every code of each two-bit field; serial and absolute bits alternate, the sleep bit is set for the last two codes.
	task automatic t_word_a();
		logic [15:0] a;
		logic [2:0] fet [4];
		fet = '{3'h1, 3'h2, 3'h4, 3'h0};
		want <= 7'h20;
		for (int i = 0; i < 4; i++) begin
			a = 16'(i | i << 3 | i << 8 | i << 10);
			a = a | 16'(i % 2) << 2 | 16'(i / 2) << 5 | 16'(i % 2) << 12;
			apb(1'b1, `OCD_ADDR_CFG_A, {16'h0, a});
			settle();
			`CHK("pfet", fet[i], precharge_fet_sel)
			`CHK("serial", 1'(i % 2), serial_indicator_mode)
			`CHK("temp", 4'h1 << i, thermal_source_sel)
			`CHK("sleep", 1'(i / 2), sleep_enter)
			`CHK("cells", 3'(i == 0 ? 0 : i + 1), series_cells)
			`CHK("invalid", 1'(i == 0), cell_count_invalid)
			`CHK("leds", 3'(i == 0 ? 0 : i + 2), indicator_count)
			`CHK("user", 1'(i == 0), indicator_user_ctrl)
			`CHK("abs", 1'(i % 2), absolute_charge_display)
			apb(1'b0, `OCD_ADDR_CFG_A, 32'h0);
			`CHK("cfg_a", {16'h0, a}, rv)
		end
	endtask

	task automatic t_reserved();
		apb(1'b1, `OCD_ADDR_CFG_A, 32'h000000C8);
		apb(1'b0, `OCD_ADDR_CFG_A, 32'h0);
		`CHK("cfg_a", 32'h00000008, rv)
		apb(1'b0, `OCD_ADDR_STATUS, 32'h0);
		`CHK("status", 32'h00000003, rv)
		apb(1'b1, `OCD_ADDR_STATUS, 32'h00000001);
		apb(1'b0, `OCD_ADDR_STATUS, 32'h0);
		`CHK("status", 32'h00000002, rv)
	endtask

	task automatic t_word_b();
		want <= 7'h40;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `OCD_ADDR_CFG_B, 32'(i));
			settle();
			`CHK("broadcast_permit", 1'(i % 2), broadcast_send)
			`CHK("hpec", 1'((i / 2) % 2), host_alarm_checksum)
			`CHK("cpec", 1'(i / 4), charger_alarm_checksum)
		end
	endtask

	task automatic t_unmapped();
		apb(1'b1, 12'h010, 32'h0000FFFF);
		`CHK("err_w", 1'b1, er)
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("err_r", 1'b1, er)
		`CHK("data_r", 32'h0, rv)
		apb(1'b0, `OCD_ADDR_CFG_B, 32'h0);
		`CHK("cfg_b", 32'h00000007, rv)
	endtask

	// Apply event levels for a few cycles and count display pulses.
	task automatic ev(input logic [6:0] w, input int n, input string s,
		input int e);
		@(posedge clock);
		p0 = pulses;
		want <= w;
		repeat (n) @(posedge clock);
		want <= 7'h00;
		repeat (4) @(posedge clock);
		#1;
		`CHK(s, e, pulses - p0)
	endtask

	task automatic t_display();
		apb(1'b1, `OCD_ADDR_CFG_A, 32'h0000E108);
		ev(7'h02, 6, "alarm", 1);
		ev(7'h10, 3, "rst_exit", 1);
		ev(7'h04, 3, "button", 3);
		ev(7'h08, 1, "cmd", 1);
		@(posedge clock);
		want <= 7'h01;
		settle();
		`CHK("chg_on", 1'b1, display_while_charging)
		apb(1'b1, `OCD_ADDR_CFG_A, 32'h00000108);
		settle();
		`CHK("chg_off", 1'b0, display_while_charging)
		ev(7'h02, 3, "alarm_off", 0);
		ev(7'h10, 3, "rst_off", 0);
		apb(1'b0, `OCD_ADDR_STATUS, 32'h0);
		`CHK("seen", 32'h00000004, rv)
		apb(1'b1, `OCD_ADDR_STATUS, 32'h00000004);
		apb(1'b0, `OCD_ADDR_STATUS, 32'h0);
		`CHK("seen_clr", 32'h00000000, rv)
	endtask

	task automatic stop_test();
		if (fails == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		#200000;
		fails++;
		stop_test();
	end

	// Main sequence: reset for eight cycles, then each scenario in turn.
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		#1;
		t_reset();
		t_word_a();
		t_reserved();
		t_word_b();
		t_unmapped();
		t_display();
		stop_test();
	end
endmodule
